// ---- logic/ppf_params.svh ----
// constants for the probe session parameter and rate field codec
`ifndef PPF_PARAMS_SVH
`define PPF_PARAMS_SVH
// frame layout: six parameter octets, then four octets per rate set
`define PPF_PARAM_OCTETS   5'h06
`define PPF_RATE_OCTETS    3'h4
`define PPF_MAX_SETS       4
`define PPF_SET_W          3
`define PPF_MAX_OCTETS     5'h16
// parameter octet positions in the frame, counted from zero
`define PPF_OCT_BACKOFF    5'h00
`define PPF_OCT_DURATION   5'h01
`define PPF_OCT_SCRAMBLER  5'h02
`define PPF_OCT_WC_MARGIN  5'h03
`define PPF_OCT_CC_MARGIN  5'h04
`define PPF_OCT_SILENCE    5'h05
// field positions; octet bit n sits at vector index n-1
`define PPF_BIT_FLAG6      5
`define PPF_BIT_SILENCE    1
`define PPF_DUR_RESERVED   6'h3F
`define PPF_DUR_MAX_LEGAL  6'h3E
`define PPF_SCR_RSV_MASK   6'h38
`define PPF_SIL_RSV_MASK   6'h3D
`define PPF_RATE_RSV_MASK  6'h38
// units of the coded values
`define PPF_BACKOFF_STEP_DB 1
`define PPF_DURATION_UNIT_MS 50
`define PPF_MARGIN_STEP_DB  1
`define PPF_MARGIN_OFFSET_DB 7'sh0A
`define PPF_MARGIN_CODE_MAX 7'sh1F
// reset and idle value of the encoder's link octet
`define PPF_RST_OCTET      8'h00
`endif

// ---- logic/ppf_pkg.sv ----
// types and shared arithmetic of the probe parameter field codec
`default_nettype none
`include "ppf_params.svh"
package ppf_pkg;

  // downstream probe session parameters as the user sees them
  typedef struct packed {
    logic [4:0]        power_backoff;  // 1 dB steps
    logic [5:0]        duration;       // 50 ms steps, 0 = unspecified
    logic [2:0]        scrambler_index_bits; // scrambler_index_bits
    logic              wc_vld;         // worst-case margin given
    logic signed [5:0] wc_db;          // worst-case margin in dB
    logic              cc_vld;         // current margin given
    logic signed [5:0] cc_db;          // current margin in dB
    logic              tx_silence;     // transmit silence requested
  } ppf_params_t;

  // one set of 7-bit base data rates
  typedef struct packed {
    logic [6:0] rmin;
    logic [6:0] rmax;
    logic [6:0] rstep;
  } ppf_rate_t;

  // encoder sequencer, gray along idle -> params -> rates
  typedef enum logic [1:0] {
    PPF_ST_IDLE  = 2'b00,
    PPF_ST_PARAM = 2'b01,
    PPF_ST_RATE  = 2'b11
  } ppf_state_t;

  // margin in dB to 5-bit code (code - 10 = dB), clamped to range
  function automatic logic [4:0] ppf_db_to_code(logic signed [5:0] db);
    logic signed [6:0] t;
    t = 7'(db) + `PPF_MARGIN_OFFSET_DB;
    if (t < 7'sh00) begin
      t = 7'sh00;
    end else if (t > `PPF_MARGIN_CODE_MAX) begin
      t = `PPF_MARGIN_CODE_MAX;
    end
    return t[4:0];
  endfunction

  // 5-bit code back to dB
  function automatic logic signed [5:0] ppf_code_to_db(logic [4:0] c);
    logic signed [6:0] t;
    t = $signed({2'b00, c}) - `PPF_MARGIN_OFFSET_DB;
    return t[5:0];
  endfunction

endpackage
`default_nettype wire

// ---- logic/ppf_link_if.sv ----
// octet link between the peer encoder and the local decoder
`timescale 1ns/1ps
`default_nettype none
interface ppf_link_if;
  logic [7:0] octet;  // one information-field octet
  logic       valid;  // octet present this cycle
  logic       last;   // final octet of the field
  modport enc (output octet, output valid, output last);
  modport dec (input octet, input valid, input last);
endinterface
`default_nettype wire

// ---- logic/ppf_field_dec.sv ----
// local end: decodes probe session parameter and rate octets
//
// Behaviour
// - octet 1: bits 5-1 backoff, bit 6 reserved
// - octet 2: duration x50ms, 0 unspecified, 63 reserved
// - octet 3: bits 6-4 zero, scrambler index
// - octet 4: bit 6 set, margin code minus 10
// - octet 4: zero unspecified, else bit6-clear reserved
// - octet 5: bit 6 set, margin code minus 10
// - octet 5: zero unspecified, else bit6-clear reserved
// - octet 6: bit 2 silence, others reserved
// - rate flag octet: msbs in bits 1-3
// - rate is flag msb over six low bits
// - rate octets 2-4 carry low six bits
// - extended sets repeat the four-octet pattern
`timescale 1ns/1ps
`default_nettype none
`include "ppf_params.svh"
module ppf_field_dec
  import ppf_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  ppf_link_if.dec                link,
  output var  ppf_params_t       params_out,
  output var  ppf_rate_t         rates_out [`PPF_MAX_SETS],
  output var  logic [`PPF_SET_W-1:0] sets_out,
  output var  logic              field_err,
  output var  logic              frame_done,
  output var  logic              frame_err
);

  ////////////////////////////////////////////////////////////////////
  // state
  logic [4:0]            cnt_r,  cnt_nxt;    // octet index in frame
  logic [2:0]            msb_r,  msb_nxt;    // rate msbs of current set
  logic                  flag_ok_r, flag_ok_nxt; // flag octet was legal
  logic                  acc_r,  acc_nxt;    // error seen this frame
  ppf_params_t           par_r,  par_nxt;
  ppf_rate_t             rate_r [`PPF_MAX_SETS];
  ppf_rate_t             rate_nxt [`PPF_MAX_SETS];
  logic [`PPF_SET_W-1:0] sets_r, sets_nxt;   // sets completed
  logic                  ferr_r, ferr_nxt;   // per-octet reject pulse
  logic                  done_r, done_nxt;
  logic                  bad_r,  bad_nxt;    // last frame's verdict

  // margin octet check shared by octets 4 and 5
  function automatic logic margin_bad(logic [5:0] b);
    return !b[`PPF_BIT_FLAG6] && (b[4:0] != 5'h00);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // next-state: decode one octet per valid cycle
  always_comb begin
    logic [5:0] b;       // the six coded bits 6..1
    logic [4:0] r;       // index inside rate area
    logic [2:0] set;     // rate set number
    logic       rej;     // this octet is rejected
    logic [4:0] n;       // octets seen including this one
    b           = link.octet[5:0];
    r           = cnt_r - `PPF_PARAM_OCTETS;
    set         = r[4:2];
    rej         = 1'b0;
    n           = cnt_r + 5'h01;
    cnt_nxt     = cnt_r;
    msb_nxt     = msb_r;
    flag_ok_nxt = flag_ok_r;
    acc_nxt     = acc_r;
    par_nxt     = par_r;
    rate_nxt    = rate_r;
    sets_nxt    = sets_r;
    done_nxt    = 1'b0;
    bad_nxt     = bad_r;
    if (link.valid) begin
      unique case (cnt_r)
        `PPF_OCT_BACKOFF: begin
          if (b[`PPF_BIT_FLAG6]) begin
            rej = 1'b1;
          end else begin
            par_nxt.power_backoff = b[4:0];
          end
        end
        `PPF_OCT_DURATION: begin
          if (b == `PPF_DUR_RESERVED) begin
            rej = 1'b1;
          end else begin
            par_nxt.duration = b;
          end
        end
        `PPF_OCT_SCRAMBLER: begin
          if ((b & `PPF_SCR_RSV_MASK) != 6'h00) begin
            rej = 1'b1;
          end else begin
            par_nxt.scrambler_index_bits = b[2:0];
          end
        end
        `PPF_OCT_WC_MARGIN: begin
          if (margin_bad(b)) begin
            rej = 1'b1;
          end else begin
            par_nxt.wc_vld = b[`PPF_BIT_FLAG6];
            par_nxt.wc_db  = b[`PPF_BIT_FLAG6] ?
                             ppf_code_to_db(b[4:0]) : 6'sh00;
          end
        end
        `PPF_OCT_CC_MARGIN: begin
          if (margin_bad(b)) begin
            rej = 1'b1;
          end else begin
            par_nxt.cc_vld = b[`PPF_BIT_FLAG6];
            par_nxt.cc_db  = b[`PPF_BIT_FLAG6] ?
                             ppf_code_to_db(b[4:0]) : 6'sh00;
          end
        end
        `PPF_OCT_SILENCE: begin
          // all-zero octet simply carries nothing, silence off
          if ((b & `PPF_SIL_RSV_MASK) != 6'h00) begin
            rej = 1'b1;
          end else begin
            par_nxt.tx_silence = b[`PPF_BIT_SILENCE];
          end
        end
        default: begin
          // rate area; sets past the storage are refused whole
          if (cnt_r >= `PPF_MAX_OCTETS) begin
            rej = 1'b1;
          end else if (r[1:0] == 2'b00) begin
            flag_ok_nxt = (b & `PPF_RATE_RSV_MASK) == 6'h00;
            rej         = !flag_ok_nxt;
            msb_nxt     = b[2:0];
          end else if (!flag_ok_r) begin
            rej = 1'b1;  // a set whose flag octet was refused
          end else begin
            unique case (r[1:0])
              2'b01:   rate_nxt[set[1:0]].rmin  = {msb_r[0], b};
              2'b10:   rate_nxt[set[1:0]].rmax  = {msb_r[1], b};
              default: rate_nxt[set[1:0]].rstep = {msb_r[2], b};
            endcase
            if (r[1:0] == 2'b11) begin
              sets_nxt = set + 3'h1;
            end
          end
        end
      endcase
      acc_nxt = acc_r | rej;
      cnt_nxt = (cnt_r == 5'h1F) ? cnt_r : n;
      if (link.last) begin
        // frame must close on a whole rate set, one set at least
        done_nxt = 1'b1;
        bad_nxt  = acc_nxt || (n < `PPF_PARAM_OCTETS + 5'h04) ||
                   (cnt_r >= `PPF_MAX_OCTETS) ||
                   (n[1:0] != 2'(`PPF_PARAM_OCTETS));
        acc_nxt  = 1'b0;
        cnt_nxt  = 5'h00;
      end
      if (cnt_r == 5'h00) begin
        sets_nxt = '0;   // fresh frame, no sets yet
      end
    end
    ferr_nxt = rej;
  end

  ////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r     <= 5'h00;
      msb_r     <= 3'h0;
      flag_ok_r <= 1'b0;
      acc_r     <= 1'b0;
      par_r     <= '0;
      rate_r    <= '{default: '0};
      sets_r    <= '0;
      ferr_r    <= 1'b0;
      done_r    <= 1'b0;
      bad_r     <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      msb_r     <= msb_nxt;
      flag_ok_r <= flag_ok_nxt;
      acc_r     <= acc_nxt;
      par_r     <= par_nxt;
      rate_r    <= rate_nxt;
      sets_r    <= sets_nxt;
      ferr_r    <= ferr_nxt;
      done_r    <= done_nxt;
      bad_r     <= bad_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  assign params_out = par_r;
  assign rates_out  = rate_r;
  assign sets_out   = sets_r;
  assign field_err  = ferr_r;
  assign frame_done = done_r;
  assign frame_err  = bad_r;

endmodule
`default_nettype wire

// ---- logic/ppf_field_enc.sv ----
// peer end: encodes probe session parameters and rates into octets
`timescale 1ns/1ps
`default_nettype none
`include "ppf_params.svh"
module ppf_field_enc
  import ppf_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  start,
  input  wire ppf_params_t           params_in,
  input  wire ppf_rate_t             rates_in [`PPF_MAX_SETS],
  input  wire logic [`PPF_SET_W-1:0] sets_in,
  output var  logic                  busy,
  ppf_link_if.enc                    link
);

  ////////////////////////////////////////////////////////////////////
  // state
  ppf_state_t  st_r,   st_nxt;
  logic [4:0]  cnt_r,  cnt_nxt;   // octet index being sent
  logic [4:0]  end_r,  end_nxt;   // index of the final octet
  ppf_params_t par_r,  par_nxt;   // latched at start
  ppf_rate_t   rate_r [`PPF_MAX_SETS];
  ppf_rate_t   rate_nxt [`PPF_MAX_SETS];
  logic [7:0]  oct_r,  oct_nxt;
  logic        vld_r,  vld_nxt;
  logic        last_r, last_nxt;
  logic        busy_r, busy_nxt;

  ////////////////////////////////////////////////////////////////////
  // next-state: one octet per cycle, no back-pressure on the link
  always_comb begin
    logic [4:0] r;     // index inside rate area
    logic [2:0] n;     // set count, clamped to 1..max
    ppf_rate_t  rs;    // rate set being sent
    r        = cnt_r - `PPF_PARAM_OCTETS;
    rs       = rate_r[r[3:2]];
    n        = sets_in;
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    end_nxt  = end_r;
    par_nxt  = par_r;
    rate_nxt = rate_r;
    oct_nxt  = `PPF_RST_OCTET;
    vld_nxt  = 1'b0;
    last_nxt = 1'b0;
    busy_nxt = busy_r;
    unique case (st_r)
      PPF_ST_IDLE: begin
        if (start) begin
          // clamp set count so a frame is always whole and legal
          if (n == 3'h0) begin
            n = 3'h1;
          end else if (n > 3'(`PPF_MAX_SETS)) begin
            n = 3'(`PPF_MAX_SETS);
          end
          end_nxt  = `PPF_PARAM_OCTETS + {n, 2'b00} - 5'h01;
          par_nxt  = params_in;
          rate_nxt = rates_in;
          cnt_nxt  = 5'h00;
          busy_nxt = 1'b1;
          st_nxt   = PPF_ST_PARAM;
        end
      end
      PPF_ST_PARAM: begin
        vld_nxt = 1'b1;
        unique case (cnt_r)
          `PPF_OCT_BACKOFF:
            oct_nxt = {3'b000, par_r.power_backoff};
          `PPF_OCT_DURATION:  // never send the reserved all-ones code
            oct_nxt = {2'b00, (par_r.duration == `PPF_DUR_RESERVED) ?
                       `PPF_DUR_MAX_LEGAL : par_r.duration};
          `PPF_OCT_SCRAMBLER:
            oct_nxt = {5'b00000, par_r.scrambler_index_bits};
          `PPF_OCT_WC_MARGIN:
            oct_nxt = par_r.wc_vld ?
                      {3'b001, ppf_db_to_code(par_r.wc_db)} : 8'h00;
          `PPF_OCT_CC_MARGIN:
            oct_nxt = par_r.cc_vld ?
                      {3'b001, ppf_db_to_code(par_r.cc_db)} : 8'h00;
          default:
            oct_nxt = {6'b000000, par_r.tx_silence, 1'b0};
        endcase
        cnt_nxt = cnt_r + 5'h01;
        if (cnt_r == `PPF_OCT_SILENCE) begin
          st_nxt = PPF_ST_RATE;
        end
      end
      PPF_ST_RATE: begin
        vld_nxt = 1'b1;
        unique case (r[1:0])
          2'b00:   oct_nxt = {5'b00000, rs.rstep[6],
                              rs.rmax[6], rs.rmin[6]};
          2'b01:   oct_nxt = {2'b00, rs.rmin[5:0]};
          2'b10:   oct_nxt = {2'b00, rs.rmax[5:0]};
          default: oct_nxt = {2'b00, rs.rstep[5:0]};
        endcase
        cnt_nxt = cnt_r + 5'h01;
        if (cnt_r == end_r) begin
          last_nxt = 1'b1;
          busy_nxt = 1'b0;
          st_nxt   = PPF_ST_IDLE;
        end
      end
      default: begin
        st_nxt = PPF_ST_IDLE;  // unused code recovers to idle
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r   <= PPF_ST_IDLE;
      cnt_r  <= 5'h00;
      end_r  <= 5'h00;
      par_r  <= '0;
      rate_r <= '{default: '0};
      oct_r  <= `PPF_RST_OCTET;
      vld_r  <= 1'b0;
      last_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      end_r  <= end_nxt;
      par_r  <= par_nxt;
      rate_r <= rate_nxt;
      oct_r  <= oct_nxt;
      vld_r  <= vld_nxt;
      last_r <= last_nxt;
      busy_r <= busy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs from flip-flops
  assign link.octet = oct_r;
  assign link.valid = vld_r;
  assign link.last  = last_r;
  assign busy       = busy_r;

endmodule
`default_nettype wire

// ---- verif/ppf_link_asserts.sv ----
// checker of the octet link between the encoder and the decoder
`timescale 1ns/1ps
`default_nettype none
module ppf_link_asserts (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] octet,
  input wire logic       valid,
  input wire logic       last
);
  ////////////////////////////////////////////////////////////////////////////
  logic [4:0] idx_r;    // octet index inside the frame
  logic [4:0] idx_nxt;  // next octet index
  logic       flag_pos; // slot of a rate flag octet
  // next index: counts octets, cleared after the last one
  always_comb begin
    idx_nxt = idx_r;
    if (valid) begin
      idx_nxt = last ? 5'h00 : idx_r + 5'h01;
    end
  end
  // register the index; a reset in mid-frame restarts the count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idx_r <= 5'h00;
    end else begin
      idx_r <= idx_nxt;
    end
  end
  // flag octets sit at 6, 10, 14 and 18
  assign flag_pos = (idx_r >= 5'h06) && (idx_r[1:0] == 2'h2);
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence oct_at(int n);
    valid && (idx_r == n);
  endsequence
  sequence mid_oct;
    valid && !last;
  endsequence
  sequence frame_end;
    valid && last;
  endsequence
  property p_burst;
    mid_oct |=> valid;
  endproperty
  backoff_rsv_a: assert property (oct_at(0) |-> !octet[5])
    else $error("backoff octet bit 6 set");
  duration_rsv_a: assert property (
    oct_at(1) |-> octet[5:0] != 6'h3F)
    else $error("duration octet reserved");
  scrambler_rsv_a: assert property (
    oct_at(2) |-> octet[5:3] == 3'h0)
    else $error("scrambler octet high bits set");
  wc_margin_a: assert property (
    oct_at(3) |-> octet[5] || !octet[4:0])
    else $error("worst-case margin reserved");
  cc_margin_a: assert property (
    oct_at(4) |-> octet[5] || !octet[4:0])
    else $error("current margin reserved");
  silence_rsv_a: assert property (
    oct_at(5) |-> !(octet[5:0] & 6'h3D))
    else $error("silence octet reserved bit");
  flag_rsv_a: assert property (
    valid && flag_pos |-> !octet[5:3])
    else $error("rate flag octet reserved bit");
  frame_len_a: assert property (
    frame_end |-> idx_r inside {9, 13, 17, 21})
    else $error("frame length not six plus whole sets");
  octet_burst_a: assert property (p_burst)
    else $error("gap inside a frame");
  // the encoder may restart one idle cycle after a last octet
  frame_gap_a: assert property (frame_end |=> !valid)
    else $error("valid held past the last octet");
  cover property (frame_end ##1 !valid);
endmodule
`default_nettype wire

// ---- verif/tb_probe_param_field_codec.sv ----
// self-checking bench joining the encoder and the decoder
`timescale 1ns/1ps
`default_nettype none
`include "ppf_params.svh"
module tb_probe_param_field_codec;
  import ppf_pkg::*;
  typedef struct packed {
    ppf_params_t p;
    ppf_rate_t   r;
    logic [2:0]  n;
  } ppf_row_t;
  logic        core_clk, rst, start, busy;
  ppf_params_t params_in, pa, pb;           // encoder input, decoded outputs
  ppf_rate_t   rates_in [`PPF_MAX_SETS];
  ppf_rate_t   ra [`PPF_MAX_SETS], rb [`PPF_MAX_SETS];
  logic [2:0]  sets_in, sa, sb;
  logic        fea, fda, fra, feb, fdb, frb; // error, done, frame error
  int          errors, comparisons, cyc;
  // rows: clamp limits, reserved duration, set counts 0 and 5
  ppf_row_t rows [4] = '{
    '{'{5'h1F,6'h3F,3'h5,1'b1,6'h34,1'b1,6'h19,1'b1},'{7'h7F,7'h00,7'h41},3'h0},
    '{'{5'h00,6'h00,3'h2,1'b0,6'h00,1'b0,6'h00,1'b0},'{7'h40,7'h3F,7'h15},3'h5},
    '{'{5'h0A,6'h3E,3'h7,1'b1,6'h15,1'b1,6'h36,1'b1},'{7'h01,7'h7E,7'h2A},3'h2},
    '{'{5'h01,6'h01,3'h0,1'b1,6'h00,1'b0,6'h00,1'b0},'{7'h55,7'h2A,7'h7F},3'h3}};
  int       bad_i [8] = '{0, 1, 2, 3, 4, 5, 6, 5};
  logic [7:0] bad_v [8] = '{8'h20, 8'h3F, 8'h10, 8'h05, 8'h01, 8'h01, 8'h08,
                            8'h20};
  ppf_link_if link ();
  ppf_link_if link2 ();  // bench drives this one to break the rules
  ppf_field_enc ppf_field_enc_inst (.core_clk(core_clk), .rst(rst),
    .start(start), .params_in(params_in), .rates_in(rates_in),
    .sets_in(sets_in), .busy(busy), .link(link.enc));
  ppf_field_dec ppf_field_dec_inst (.core_clk(core_clk), .rst(rst),
    .link(link.dec), .params_out(pa), .rates_out(ra), .sets_out(sa),
    .field_err(fea), .frame_done(fda), .frame_err(fra));
  ppf_field_dec ppf_field_dec_inst2 (.core_clk(core_clk), .rst(rst),
    .link(link2.dec), .params_out(pb), .rates_out(rb), .sets_out(sb),
    .field_err(feb), .frame_done(fdb), .frame_err(frb));
  ppf_link_asserts ppf_link_asserts_inst (.core_clk(core_clk), .rst(rst),
    .octet(link.octet), .valid(link.valid), .last(link.last));
  ////////////////////////////////////////////////////////////////////////////
  // clock, and a cycle ceiling well above the few hundred cycles used
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // margin in dB to code, clamped to -10..21 dB
  function automatic logic [4:0] mcode(logic signed [5:0] db);
    int t;
    t = int'(db) + 10;
    return (t < 0) ? 5'h00 : (t > 31) ? 5'h1F : 5'(t);
  endfunction
  function automatic ppf_rate_t rset(ppf_rate_t r, int s);
    return '{r.rmin ^ 7'(s * 73), r.rmax ^ 7'(s * 49), r.rstep ^ 7'(s * 98)};
  endfunction
  function automatic int nsets(logic [2:0] n);
    return (n == 3'h0) ? 1 : (n > 3'h4) ? 4 : int'(n);
  endfunction
  // decoded view: duration 63 goes out as 62, margins clamped
  function automatic ppf_params_t dec_of(ppf_params_t p);
    ppf_params_t e;
    e = p;
    if (p.duration == 6'h3F) e.duration = 6'h3E;
    e.wc_db = p.wc_vld ? 6'(mcode(p.wc_db)) - 6'h0A : 6'h00;
    e.cc_db = p.cc_vld ? 6'(mcode(p.cc_db)) - 6'h0A : 6'h00;
    return e;
  endfunction
  // expected octet i of the frame for a row
  function automatic logic [7:0] exp_oct(ppf_row_t x, int i);
    ppf_params_t e;
    ppf_rate_t   q;
    e = dec_of(x.p);
    q = rset(x.r, (i - 6) / 4);
    case (i)
      0: return {3'h0, e.power_backoff};
      1: return {2'h0, e.duration};
      2: return {5'h00, e.scrambler_index_bits};
      3: return e.wc_vld ? {3'h1, mcode(e.wc_db)} : 8'h00;
      4: return e.cc_vld ? {3'h1, mcode(e.cc_db)} : 8'h00;
      5: return {6'h00, e.tx_silence, 1'b0};
      default: case ((i - 6) % 4)
        0: return {5'h00, q.rstep[6], q.rmax[6], q.rmin[6]};
        1: return {2'h0, q.rmin[5:0]};
        2: return {2'h0, q.rmax[5:0]};
        default: return {2'h0, q.rstep[5:0]};
      endcase
    endcase
  endfunction
  // one frame through the encoder; glitch gives a start while busy
  task automatic run_row(ppf_row_t x, bit glitch);
    int n, w;
    n = nsets(x.n);
    @(negedge core_clk);
    params_in = x.p;
    for (int s = 0; s < 4; s++) rates_in[s] = rset(x.r, s);
    sets_in = x.n;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    w = 0;
    while (link.valid !== 1'b1 && w < 8) begin
      @(negedge core_clk);
      w++;
    end
    for (int i = 0; i < 6 + 4 * n; i++) begin
      chk(link.octet, exp_oct(x, i));
      chk(link.last, i == 5 + 4 * n);
      if (glitch) begin
        params_in = ~x.p;
        start = (i == 2);
      end
      @(negedge core_clk);
    end
    chk({fda, fra, fea, sa, busy, link.valid}, {3'b100, 3'(n), 2'b00});
    chk(pa, dec_of(x.p));
    for (int s = 0; s < n; s++) chk(ra[s], rset(x.r, s));
    @(negedge core_clk);
    chk(link.valid, 1'b0);
    $display("test done: row frame");
  endtask
  // frame on the second link, one octet swapped for a bad one
  task automatic frame2(int bad, logic [7:0] bv, int len, logic [7:0] top,
                        logic ferr);
    for (int i = 0; i <= len; i++) begin
      @(negedge core_clk);
      if (i > 0 && i - 1 <= bad) chk(feb, i - 1 == bad);
      link2.valid = (i < len);
      link2.last = (i == len - 1);
      link2.octet = (i == len) ? ~link2.octet :
                    (i == bad) ? bv : exp_oct(rows[0], i) | top;
    end
    chk({fdb, frb}, {1'b1, ferr});
    chk(sb, len >= 10 && bad != 6);
    chk(pb, dec_of(rows[0].p));
    chk(rb[0], rset(rows[0].r, 0));
    $display("test done: fault frame");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    comparisons = 0;
    cyc = 0;
    rst = 1'b1;
    start = 1'b0;
    params_in = '0;
    sets_in = 3'h0;
    for (int s = 0; s < 4; s++) rates_in[s] = '0;
    link2.octet = 8'h00;
    link2.valid = 1'b0;
    link2.last = 1'b0;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    chk({pa, sa, fea, fda, fra, busy, link.valid}, '0);
    $display("test done: reset");
    foreach (rows[k]) run_row(rows[k], 1'b0);
    run_row(rows[2], 1'b1);
    frame2(99, 8'h00, 10, 8'hC0, 1'b0);
    for (int k = 0; k < 8; k++) frame2(bad_i[k], bad_v[k], 10, 8'h00, 1'b1);
    frame2(99, 8'h00, 7, 8'h00, 1'b1);
    // reset in mid-frame, then a clean frame
    @(negedge core_clk);
    params_in = rows[3].p;
    start = 1'b1;
    repeat (4) @(negedge core_clk);
    start = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    chk({pa, busy, link.valid}, '0);
    run_row(rows[3], 1'b0);
    $display("test done: mid-run reset");
    end_sim();
  end
endmodule
`default_nettype wire
